/* hdl/rcdr_regs.svh */
// constants for the reset cause and debug reset block: field positions, reset
// values, service codes and the reset stretch time.
// assumes inclusion by bare name from any design file that needs them.
`ifndef RCDR_REGS_SVH
`define RCDR_REGS_SVH

// ---------------------------------------------------------------
// reset_cause field positions
// ---------------------------------------------------------------
`define RCDR_BIT_POWER_ON 7
`define RCDR_BIT_PIN 6
`define RCDR_BIT_WATCHDOG 5
`define RCDR_BIT_ILLEGAL_OPCODE 4
`define RCDR_BIT_ILLEGAL_ADDRESS 3
`define RCDR_BIT_LOW_VOLTAGE 1

// ---------------------------------------------------------------
// reset values and fixed read values
// ---------------------------------------------------------------
`define RCDR_CAUSE_POR_VALUE 8'h82
`define RCDR_CAUSE_UNUSED_MASK 8'h05
`define RCDR_DEBUG_FORCE_READ 8'h00
`define RCDR_FORCE_RESET_BIT 0

// ---------------------------------------------------------------
// watchdog service codes
// ---------------------------------------------------------------
`define RCDR_SERVICE_FIRST 8'h55
`define RCDR_SERVICE_SECOND 8'haa
`define RCDR_TIMEOUT_OFF 2'h0

// ---------------------------------------------------------------
// timing: least reset stretch after the sources release
// ---------------------------------------------------------------
`define RCDR_CLOCK_PERIOD_NS 40
`define RCDR_STRETCH_NS 320
`define RCDR_STRETCH_CYCLES \
  ((`RCDR_STRETCH_NS + `RCDR_CLOCK_PERIOD_NS - 1) / `RCDR_CLOCK_PERIOD_NS)
`define RCDR_STRETCH_WIDTH 4

`endif

/* hdl/rcdr_pkg.sv */
// types shared by the reset cause block and its watchdog service tracker.
// assumes rcdr_regs.svh supplies the numeric constants.
package rcdr_pkg;

  // ---------------------------------------------------------------
  // state types, one bit changing per step along the usual path except RS_STRETCH to RS_RUN
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RS_RUN = 2'h0,
    RS_ASSERT = 2'h1,
    RS_STRETCH = 2'h3
  } rcdr_rst_state_t;

  typedef enum logic {
    SV_IDLE = 1'h0,
    SV_GOT_FIRST = 1'h1
  } rcdr_svc_state_t;

endpackage

/* hdl/rcdr_service.sv */
// watchdog service tracker: watches writes to the reset_cause address and
// reports a restart or a violation one cycle later.
// assumes the watchdog timer outside supplies enable and window position.
`timescale 1ns/1ps
`include "rcdr_regs.svh"

module rcdr_service (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  // write to the reset_cause address
  input wire logic cause_wr,
  input wire logic [7:0] wr_data,
  // watchdog configuration and window position
  input wire logic wd_enabled,
  input wire logic window_mode,
  input wire logic in_last_quarter,
  // results
  output rcdr_pkg::rcdr_svc_state_t state_ff,
  output logic restart_ff,
  output logic violation_ff
);
  import rcdr_pkg::*;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic is_first = (wr_data == `RCDR_SERVICE_FIRST);
  wire logic is_second = (wr_data == `RCDR_SERVICE_SECOND);
  wire logic wr_live = cause_wr && wd_enabled && !clear;
  // early writes in window mode count as faults even when they are valid codes
  wire logic early = window_mode && !in_last_quarter;
  wire logic nxt_violation = wr_live && ((!is_first && !is_second) || early);
  wire logic nxt_restart = wr_live && !early && is_second && (state_ff == SV_GOT_FIRST);
  rcdr_svc_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (clear || nxt_violation) begin
      nxt_state = SV_IDLE;
    end else if (wr_live) begin
      nxt_state = is_first ? SV_GOT_FIRST : SV_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= SV_IDLE;
      restart_ff <= 1'b0;
      violation_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      restart_ff <= nxt_restart;
      violation_ff <= nxt_violation;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_bad_code;
    @(posedge clock) disable iff (rst)
    (wr_live && !is_first && !is_second) |=> violation_ff;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad code did not fault");

  property p_service_pair;
    @(posedge clock) disable iff (rst)
    (wr_live && !early && is_first) ##1 (wr_live && !early && is_second)
      |=> restart_ff && !violation_ff;
  endproperty
  a_service_pair: assert property (p_service_pair) else $error("pair did not restart");

  property p_early_write;
    @(posedge clock) disable iff (rst)
    (wr_live && window_mode && !in_last_quarter) |=> violation_ff && !restart_ff;
  endproperty
  a_early_write: assert property (p_early_write) else $error("early write not faulted");

  c_restart: cover property (@(posedge clock) disable iff (rst) restart_ff);

endmodule

/* hdl/rcdr_top.sv */
// reset cause recorder with watchdog service decode and debug forced reset.
// assumes cpu and debug strobes are synchronous one-cycle pulses and that
// rst is the power-on reset of this block alone.
//
// Operation
// - reset_cause flags are read-only; ordinary writes never alter them.
// - a debug forced reset leaves every reset_cause flag cleared.
// - watchdog enabled: a cause write other than 0x55/0xaa forces watchdog reset.
// - writing 0x55 then 0xaa restarts the watchdog, flags untouched.
// - power-on sets bit 7 and low-voltage bit 1, clears the rest.
// - low-voltage reset sets bit 1, clears bits 6..3, keeps bit 7.
// - other resets set active source flags, clear the rest and bits 7, 1.
// - a low level on the external reset pin is recorded in bit 6.
// - watchdog timeout recorded in bit 5; blocked when timeout select is zero.
// - illegal opcode, disabled stop or background instruction resets, sets bit 4.
// - access to an unimplemented address resets and sets bit 3.
// - debug_force_reset writes are honoured only from serial debug commands.
// - reads of debug_force_reset always return 0x00.
// - debug writing 1 to the force reset bit starts a system reset at once.
// - window mode: service writes in the first 75% of the period reset.
// - low-voltage reset only when enabled; held until the supply recovers.
`timescale 1ns/1ps
`include "rcdr_regs.svh"

module rcdr_top (
  // clock and power-on reset
  input wire logic clock,
  input wire logic rst,
  // register access
  input wire logic sel_reset_cause,
  input wire logic sel_debug_force_reset,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic from_debug,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data_ff,
  // reset sources
  input wire logic reset_pin_n,
  input wire logic supply_low,
  input wire logic low_voltage_reset_enable,
  input wire logic unimplemented_opcode,
  input wire logic stop_instruction,
  input wire logic background_instruction,
  input wire logic stop_mode_enable,
  input wire logic background_mode_enable,
  input wire logic illegal_address_access,
  // watchdog timer link
  input wire logic [1:0] watchdog_timeout_select,
  input wire logic watchdog_window_mode,
  input wire logic watchdog_last_quarter,
  input wire logic watchdog_timeout,
  output logic watchdog_restart_ff,
  // system reset
  output logic sys_reset_ff,
  output logic [7:0] reset_cause_ff
);
  import rcdr_pkg::*;

  // ---------------------------------------------------------------
  // reset source decode
  // ---------------------------------------------------------------
  rcdr_rst_state_t state_ff;
  rcdr_rst_state_t nxt_state;
  rcdr_svc_state_t svc_state;
  logic [`RCDR_STRETCH_WIDTH-1:0] stretch_ff;
  logic [`RCDR_STRETCH_WIDTH-1:0] nxt_stretch;
  logic [7:0] nxt_cause;
  logic service_violation;

  wire logic in_run = (state_ff == RS_RUN);
  wire logic wd_enabled = (watchdog_timeout_select != `RCDR_TIMEOUT_OFF);
  wire logic cause_wr = wr_en && sel_reset_cause;
  wire logic src_pin = !reset_pin_n;
  wire logic src_wd = (watchdog_timeout && wd_enabled) || service_violation;
  wire logic src_illegal_opcode_flag = unimplemented_opcode
    || (stop_instruction && !stop_mode_enable)
    || (background_instruction && !background_mode_enable);
  wire logic src_illegal_address_flag = illegal_address_access;
  wire logic src_lvr = supply_low && low_voltage_reset_enable;
  // user program writes never reach the force bit
  wire logic src_dbg = wr_en && sel_debug_force_reset && from_debug
    && wr_data[`RCDR_FORCE_RESET_BIT];
  wire logic src_other = src_pin || src_wd || src_illegal_opcode_flag || src_illegal_address_flag;
  wire logic any_src = src_lvr || src_dbg || src_other;
  // only the level sources keep the chip in reset; pulses go straight to the stretch
  wire logic held = src_lvr || src_pin;

  // ---------------------------------------------------------------
  // watchdog service tracker
  // ---------------------------------------------------------------
  rcdr_service u_service (
    .clock(clock),
    .rst(rst),
    .clear(sys_reset_ff),
    .cause_wr(cause_wr),
    .wr_data(wr_data),
    .wd_enabled(wd_enabled),
    .window_mode(watchdog_window_mode),
    .in_last_quarter(watchdog_last_quarter),
    .state_ff(svc_state),
    .restart_ff(watchdog_restart_ff),
    .violation_ff(service_violation)
  );

  // ---------------------------------------------------------------
  // cause capture at reset entry
  // ---------------------------------------------------------------
  // low voltage wins over a simultaneous debug or event source, since the
  // supply itself is suspect; debug wins over events so that a forced
  // reset leaves a clean register for the host.
  always_comb begin
    nxt_cause = reset_cause_ff;
    if (in_run && src_lvr) begin
      nxt_cause = 8'h00;
      nxt_cause[`RCDR_BIT_LOW_VOLTAGE] = 1'b1;
      nxt_cause[`RCDR_BIT_POWER_ON] = reset_cause_ff[`RCDR_BIT_POWER_ON];
    end else if (in_run && src_dbg) begin
      nxt_cause = 8'h00;
    end else if (in_run && src_other) begin
      nxt_cause = 8'h00;
      nxt_cause[`RCDR_BIT_PIN] = src_pin;
      nxt_cause[`RCDR_BIT_WATCHDOG] = src_wd;
      nxt_cause[`RCDR_BIT_ILLEGAL_OPCODE] = src_illegal_opcode_flag;
      nxt_cause[`RCDR_BIT_ILLEGAL_ADDRESS] = src_illegal_address_flag;
    end
  end

  // ---------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_stretch = stretch_ff;
    case (state_ff)
      RS_RUN: begin
        if (any_src) begin
          nxt_state = RS_ASSERT;
        end
      end
      RS_ASSERT: begin
        if (!held) begin
          nxt_state = RS_STRETCH;
          nxt_stretch = `RCDR_STRETCH_WIDTH'(`RCDR_STRETCH_CYCLES - 1);
        end
      end
      RS_STRETCH: begin
        if (held) begin
          nxt_state = RS_ASSERT;
        end else if (stretch_ff == '0) begin
          nxt_state = RS_RUN;
        end else begin
          nxt_stretch = stretch_ff - 1'b1;
        end
      end
      default: begin
        nxt_state = RS_ASSERT;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  wire logic [7:0] cause_view = reset_cause_ff & ~`RCDR_CAUSE_UNUSED_MASK;
  wire logic [7:0] nxt_rd_data = (rd_en && sel_reset_cause) ? cause_view
    : `RCDR_DEBUG_FORCE_READ;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= RS_ASSERT;
      stretch_ff <= '0;
      sys_reset_ff <= 1'b1;
      reset_cause_ff <= `RCDR_CAUSE_POR_VALUE;
      rd_data_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      stretch_ff <= nxt_stretch;
      sys_reset_ff <= (nxt_state != RS_RUN);
      reset_cause_ff <= nxt_cause;
      rd_data_ff <= nxt_rd_data;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_flags_read_only;
    (in_run && !any_src && cause_wr) |=> $stable(reset_cause_ff);
  endproperty
  a_flags_read_only: assert property (p_flags_read_only) else $error("write changed flags");

  property p_debug_clears;
    (in_run && src_dbg && !src_lvr) |=> (reset_cause_ff == 8'h00) && sys_reset_ff;
  endproperty
  a_debug_clears: assert property (p_debug_clears) else $error("debug reset left flags");

  property p_low_voltage;
    (in_run && src_lvr) |=> reset_cause_ff[`RCDR_BIT_LOW_VOLTAGE]
      && (reset_cause_ff[6:3] == 4'h0)
      && (reset_cause_ff[`RCDR_BIT_POWER_ON] == $past(reset_cause_ff[`RCDR_BIT_POWER_ON]));
  endproperty
  a_low_voltage: assert property (p_low_voltage) else $error("low voltage capture wrong");

  property p_other_capture;
    (in_run && !src_lvr && !src_dbg && src_other) |=>
      reset_cause_ff == {1'b0, $past(src_pin), $past(src_wd), $past(src_illegal_opcode_flag),
      $past(src_illegal_address_flag), 3'b000};
  endproperty
  a_other_capture: assert property (p_other_capture) else $error("event capture wrong");

  property p_timeout_blocked;
    (in_run && watchdog_timeout && !wd_enabled && !any_src) |=> !sys_reset_ff;
  endproperty
  a_timeout_blocked: assert property (p_timeout_blocked) else $error("blocked timeout reset");

  property p_unused_zero;
    (rd_data_ff[2] == 1'b0) && (rd_data_ff[0] == 1'b0);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit read as one");

  property p_user_ignored;
    (in_run && wr_en && sel_debug_force_reset && !from_debug && !any_src) |=> !sys_reset_ff;
  endproperty
  a_user_ignored: assert property (p_user_ignored) else $error("user write forced reset");

  property p_debug_read_zero;
    (rd_en && sel_debug_force_reset && !sel_reset_cause) |=> (rd_data_ff == 8'h00);
  endproperty
  a_debug_read_zero: assert property (p_debug_read_zero) else $error("force reg read nonzero");

  property p_force_now;
    (in_run && src_dbg) |=> sys_reset_ff [*2];
  endproperty
  a_force_now: assert property (p_force_now) else $error("forced reset not immediate");

  property p_lvr_hold;
    (!in_run && src_lvr) |=> sys_reset_ff && (state_ff == RS_ASSERT);
  endproperty
  a_lvr_hold: assert property (p_lvr_hold) else $error("reset released under low supply");

  property p_lvr_disabled;
    (in_run && supply_low && !low_voltage_reset_enable && !src_dbg && !src_other)
      |=> !sys_reset_ff;
  endproperty
  a_lvr_disabled: assert property (p_lvr_disabled) else $error("disabled lvr reset");

  property p_pin_flag;
    (in_run && src_pin && !src_lvr && !src_dbg) |=> reset_cause_ff[`RCDR_BIT_PIN];
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin flag not set");

  property p_stop_illegal;
    (in_run && stop_instruction && !stop_mode_enable && !src_lvr && !src_dbg)
      |=> reset_cause_ff[`RCDR_BIT_ILLEGAL_OPCODE] && sys_reset_ff;
  endproperty
  a_stop_illegal: assert property (p_stop_illegal) else $error("illegal stop missed");

  property p_bad_address;
    (in_run && src_illegal_address_flag && !src_lvr && !src_dbg)
      |=> reset_cause_ff[`RCDR_BIT_ILLEGAL_ADDRESS] && sys_reset_ff;
  endproperty
  a_bad_address: assert property (p_bad_address) else $error("illegal address missed");

  property p_background_illegal;
    (in_run && background_instruction && !background_mode_enable && !src_lvr && !src_dbg)
      |=> reset_cause_ff[`RCDR_BIT_ILLEGAL_OPCODE] && sys_reset_ff;
  endproperty
  a_background_illegal: assert property (p_background_illegal) else $error("bad background_instruction missed");

  property p_violation_resets;
    (in_run && service_violation && !src_lvr && !src_dbg)
      |=> sys_reset_ff && reset_cause_ff[`RCDR_BIT_WATCHDOG];
  endproperty
  a_violation_resets: assert property (p_violation_resets) else $error("fault not reset");

  property p_blocked_flag;
    (in_run && src_other && !src_lvr && !src_dbg && !wd_enabled && !service_violation)
      |=> !reset_cause_ff[`RCDR_BIT_WATCHDOG];
  endproperty
  a_blocked_flag: assert property (p_blocked_flag) else $error("watchdog flag while off");

  // flags only move at reset entry; sources seen while in reset are ignored
  property p_cause_frozen;
    !in_run |=> $stable(reset_cause_ff);
  endproperty
  a_cause_frozen: assert property (p_cause_frozen) else $error("flags moved in reset");

  property p_force_bit_clear;
    (in_run && wr_en && sel_debug_force_reset && from_debug
      && !wr_data[`RCDR_FORCE_RESET_BIT] && !src_lvr && !src_other) |=> !sys_reset_ff;
  endproperty
  a_force_bit_clear: assert property (p_force_bit_clear) else $error("zero bit forced reset");

  property p_stretch_release;
    (state_ff == RS_STRETCH && !held && stretch_ff == '0) |=> !sys_reset_ff;
  endproperty
  a_stretch_release: assert property (p_stretch_release) else $error("stretch overran");

  c_debug_reset: cover property (in_run && src_dbg);
  c_lvr_reset: cover property (in_run && src_lvr);
  c_wd_reset: cover property (in_run && src_wd && !src_lvr && !src_dbg);
  c_service_arm: cover property (svc_state == SV_GOT_FIRST);

endmodule

/* verification/rcdr_host_model.sv */
// cpu bus and serial debug host model for the reset cause block.
// assumes the block samples on the rising edge; this model drives at the falling edge.
`timescale 1ns/1ps

module rcdr_host_model (
  // clock and read return
  input wire logic clock,
  input wire logic [7:0] rd_data_ff,
  // register access
  output logic sel_reset_cause,
  output logic sel_debug_force_reset,
  output logic wr_en,
  output logic rd_en,
  output logic from_debug,
  output logic [7:0] wr_data
);
  initial begin
    sel_reset_cause = 1'b0;
    sel_debug_force_reset = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    from_debug = 1'b0;
    wr_data = 8'h00;
  end

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  // released data is inverted so a stale value can never pass for a fresh one
  task access(input logic dbg, input logic wr, input logic csel, input logic [7:0] d,
              output logic [7:0] q);
    @(negedge clock);
    sel_reset_cause = csel;
    sel_debug_force_reset = !csel;
    from_debug = dbg;
    wr_en = wr;
    rd_en = !wr;
    wr_data = d;
    @(negedge clock);
    q = rd_data_ff;
    sel_reset_cause = 1'b0;
    sel_debug_force_reset = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_data = ~d;
  endtask

  // caller keeps this inside the last quarter when window mode is on;
  // both codes go out on back-to-back cycles with the strobe held up
  task service();
    @(negedge clock);
    sel_reset_cause = 1'b1;
    sel_debug_force_reset = 1'b0;
    from_debug = 1'b0;
    rd_en = 1'b0;
    wr_en = 1'b1;
    wr_data = 8'h55;
    @(negedge clock);
    wr_data = 8'haa;
    @(negedge clock);
    sel_reset_cause = 1'b0;
    wr_en = 1'b0;
    wr_data = 8'h55;
  endtask

  // only a debug command may carry this write
  task force_reset();
    logic [7:0] q;
    access(1'b1, 1'b1, 1'b0, 8'h01, q);
  endtask
endmodule

/* verification/tb_reset_cause_and_debug_reset.sv */
// self-checking bench for the reset cause recorder and debug forced reset.
// assumes rcdr_host_model supplies the register strobes.
`timescale 1ns/1ps

module tb_reset_cause_and_debug_reset;
  logic clock, rst, reset_pin_n, supply_low, low_voltage_reset_enable;
  logic stop_mode_enable, background_mode_enable, watchdog_window_mode, watchdog_last_quarter;
  logic sel_reset_cause, sel_debug_force_reset, wr_en, rd_en, from_debug;
  logic watchdog_restart_ff, sys_reset_ff;
  logic [1:0] watchdog_timeout_select;
  logic [4:0] ev;
  logic [7:0] wr_data, rd_data_ff, reset_cause_ff, q;
  int bad_count, total_checks;
  // event masks: opcode, stop, background, address, opcode with address
  localparam logic [4:0] EV_M [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h12};
  localparam logic [7:0] EV_F [5] = '{8'h10, 8'h10, 8'h10, 8'h08, 8'h18};

  rcdr_top u_rcdr_top (
    .clock, .rst, .sel_reset_cause, .sel_debug_force_reset, .wr_en, .rd_en, .from_debug,
    .wr_data, .rd_data_ff, .reset_pin_n, .supply_low, .low_voltage_reset_enable,
    .unimplemented_opcode(ev[4]), .stop_instruction(ev[3]), .background_instruction(ev[2]),
    .stop_mode_enable, .background_mode_enable, .illegal_address_access(ev[1]),
    .watchdog_timeout_select, .watchdog_window_mode, .watchdog_last_quarter,
    .watchdog_timeout(ev[0]), .watchdog_restart_ff, .sys_reset_ff, .reset_cause_ff
  );
  rcdr_host_model u_rcdr_host_model (
    .clock, .rd_data_ff, .sel_reset_cause, .sel_debug_force_reset, .wr_en, .rd_en,
    .from_debug, .wr_data
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] d);
    u_rcdr_host_model.access(1'b0, 1'b1, 1'b1, d, q);
  endtask

  task rd_cause(input logic [7:0] exp);
    u_rcdr_host_model.access(1'b0, 1'b0, 1'b1, 8'h00, q);
    check(q, exp);
  endtask

  task exp_rst(input logic [7:0] f);
    int n;
    n = 0;
    while (sys_reset_ff !== 1'b1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    check({7'h00, sys_reset_ff}, 8'h01);
    check(reset_cause_ff, f);
  endtask

  // bounded wait for the stretch to end, then read the flags back over the bus
  task settle(input logic [7:0] f);
    int n;
    n = 0;
    while (sys_reset_ff !== 1'b0 && n < 40) begin
      @(negedge clock);
      n++;
    end
    check({7'h00, sys_reset_ff}, 8'h00);
    rd_cause(f);
  endtask

  task quiet();
    repeat (6) begin
      @(negedge clock);
      check({6'h00, sys_reset_ff, watchdog_restart_ff}, 8'h00);
    end
  endtask

  task got_restart();
    int n;
    n = 0;
    while (watchdog_restart_ff !== 1'b1 && n < 4) begin
      @(negedge clock);
      n++;
    end
    check({7'h00, watchdog_restart_ff}, 8'h01);
    @(negedge clock);
    check({7'h00, watchdog_restart_ff}, 8'h00);
  endtask

  task pulse(input logic [4:0] m);
    @(negedge clock);
    ev = m;
    @(negedge clock);
    ev = 5'h00;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task s_read_only();
    watchdog_timeout_select = 2'h0;
    wr(8'h00);
    wr(8'h12);
    quiet();
    rd_cause(8'h82);
  endtask

  task s_debug_reg();
    u_rcdr_host_model.access(1'b0, 1'b0, 1'b0, 8'h00, q);
    check(q, 8'h00);
    u_rcdr_host_model.access(1'b0, 1'b1, 1'b0, 8'h01, q);
    quiet();
    u_rcdr_host_model.access(1'b1, 1'b1, 1'b0, 8'hfe, q);
    quiet();
    u_rcdr_host_model.access(1'b1, 1'b0, 1'b0, 8'h00, q);
    check(q, 8'h00);
  endtask

  // power-on flag survives a low-voltage reset
  task s_low_voltage();
    supply_low = 1'b1;
    quiet();
    low_voltage_reset_enable = 1'b1;
    exp_rst(8'h82);
    repeat (20) @(negedge clock);
    check({7'h00, sys_reset_ff}, 8'h01);
    supply_low = 1'b0;
    settle(8'h82);
  endtask

  task s_service();
    watchdog_timeout_select = 2'h1;
    wr(8'h55);
    u_rcdr_host_model.service();
    got_restart();
    rd_cause(8'h82);
    wr(8'haa);
    quiet();
    wr(8'h12);
    exp_rst(8'h20);
    settle(8'h20);
  endtask

  task s_events();
    watchdog_timeout_select = 2'h0;
    stop_mode_enable = 1'b1;
    background_mode_enable = 1'b1;
    pulse(5'h0c);
    quiet();
    pulse(5'h01);
    quiet();
    stop_mode_enable = 1'b0;
    background_mode_enable = 1'b0;
    for (int i = 0; i < 5; i++) begin
      pulse(EV_M[i]);
      exp_rst(EV_F[i]);
      settle(EV_F[i]);
    end
  endtask

  // after a forced reset the power-on flag is clear, so low voltage shows alone
  task s_debug_force();
    u_rcdr_host_model.force_reset();
    exp_rst(8'h00);
    settle(8'h00);
    supply_low = 1'b1;
    exp_rst(8'h02);
    supply_low = 1'b0;
    settle(8'h02);
  endtask

  task s_pin();
    reset_pin_n = 1'b0;
    exp_rst(8'h40);
    repeat (20) @(negedge clock);
    check({7'h00, sys_reset_ff}, 8'h01);
    reset_pin_n = 1'b1;
    settle(8'h40);
    watchdog_timeout_select = 2'h3;
    pulse(5'h01);
    exp_rst(8'h20);
    settle(8'h20);
  endtask

  task s_window();
    watchdog_window_mode = 1'b1;
    watchdog_last_quarter = 1'b1;
    u_rcdr_host_model.service();
    got_restart();
    watchdog_last_quarter = 1'b0;
    wr(8'h55);
    exp_rst(8'h20);
    settle(8'h20);
  endtask

  task results();
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    reset_pin_n = 1'b1;
    supply_low = 1'b0;
    low_voltage_reset_enable = 1'b0;
    stop_mode_enable = 1'b0;
    background_mode_enable = 1'b0;
    watchdog_window_mode = 1'b0;
    watchdog_last_quarter = 1'b0;
    watchdog_timeout_select = 2'h0;
    ev = 5'h00;
    bad_count = 0;
    total_checks = 0;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    settle(8'h82);
    s_read_only();
    s_debug_reg();
    s_low_voltage();
    s_service();
    s_events();
    s_debug_force();
    s_pin();
    s_window();
    results();
  end

  // the full run needs well under 3000 cycles
  initial begin
    #400000;
    bad_count++;
    results();
  end
endmodule
